// file: include/pwl_pkg.sv
package pwl_pkg;

  // Register byte offsets on the device register bus
  localparam logic [7:0] KEY_BYTE0_OFFSET     = 8'h21;
  localparam logic [7:0] KEY_BYTE1_OFFSET     = 8'h22;
  localparam logic [7:0] KEY_BYTE2_OFFSET     = 8'h23;
  localparam logic [7:0] KEY_BYTE3_OFFSET     = 8'h24;
  localparam logic [7:0] NVM_ADDR_OFFSET      = 8'h25;
  localparam logic [7:0] NVM_DATA_OFFSET      = 8'h26;

  // Configuration memory locations of the lock settings
  localparam logic [7:0] NVM_LOCK_ENABLE_LOC  = 8'h30;
  localparam logic [7:0] NVM_KEY_LOW_LOC      = 8'h31;
  localparam logic [7:0] NVM_KEY_HIGH_LOC     = 8'h34;
  localparam logic [7:0] LOCK_ENABLE_VALUE    = 8'hFF;

  // Values after reset
  localparam logic [7:0] KEY_BYTE_RESET       = 8'h00;
  localparam logic [7:0] NVM_ADDR_RESET       = 8'h00;
  localparam logic [7:0] NVM_DATA_RESET       = 8'h00;
  localparam logic [7:0] READ_ZERO            = 8'h00;

  // Power-on refresh time and derived cycle count at 40 MHz
  localparam int unsigned REFRESH_TIME_MS     = 66;
  localparam int unsigned CLK_FREQ_HZ         = 40000000;
  localparam int unsigned REFRESH_CYCLES      = REFRESH_TIME_MS * (CLK_FREQ_HZ / 1000);

  // Host register access request
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } pwl_req_s;

  // Lock settings mirrored out of configuration memory
  typedef struct packed {
    logic [7:0]  enable;
    logic [31:0] storedKey;
  } pwl_nv_s;

endpackage

// file: src/pwl_key_compare.sv
`timescale 1ns/1ps
// Registered key comparison; one cycle of latency keeps the bus decode short
module pwl_key_compare
  import pwl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [31:0] enteredKey,
  input  wire pwl_nv_s     nvSettings,
  output logic             lockActive,
  output logic             writeAllowed
);

  // Protection is on only for the exact enable value
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lockActive <= 1'b1;  // Safe side until settings are known
    end
    else
    begin
      lockActive <= (nvSettings.enable == LOCK_ENABLE_VALUE);
    end
  end

  // Writes pass when unlocked or when the key matches
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      writeAllowed <= 1'b0;
    end
    else
    begin
      writeAllowed <= (nvSettings.enable != LOCK_ENABLE_VALUE)
                      || (enteredKey == nvSettings.storedKey);
    end
  end

endmodule

// file: src/pwl_write_lock.sv
`timescale 1ns/1ps
module pwl_write_lock
  import pwl_pkg::*;
#(
  parameter int unsigned REFRESH_COUNT = REFRESH_CYCLES  // Shorten in simulation
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire pwl_req_s    hostReq,
  input  wire pwl_nv_s     nvSettings,
  input  wire logic        nvDataLoad,
  input  wire logic [7:0]  nvDataIn,
  output logic [7:0]       rdData,
  output logic             rdValid,
  output logic             protWriteEnable,
  output logic             lockActive,
  output logic             refreshDone,
  output logic [7:0]       nvmByteAddress,
  output logic [7:0]       nvmByteData
);

  logic [7:0]  keyByteLow_reg;     // Key bits 7:0
  logic [7:0]  keyByteSecond_reg;  // Key bits 15:8
  logic [7:0]  keyByteThird_reg;   // Key bits 23:16
  logic [7:0]  keyByteHigh_reg;    // Key bits 31:24
  logic [31:0] enteredKey;         // Assembled key
  logic        allowRaw;           // From comparator, guards every write except key bytes
  logic        refreshCount_done;  // Counter reached end
  logic [31:0] refreshCnt_reg;     // Power-on refresh timer
  logic        keyWrite;           // Any key byte being written
  logic        protectedWrite;     // Write to a lock-guarded register

  typedef enum logic [1:0] {PWL_REFRESH, PWL_CLEAR, PWL_RUN} pwl_state_e;
  pwl_state_e state_reg;           // Power-up sequencing
  pwl_state_e state_next;

  // Key entry timing, one byte write after another:
  //   edge n    last key byte lands in its lane
  //   edge n+1  comparator registers the match; guarded writes pass from here
  //   edge n+1  lockActive falls in the same cycle as the gate opens
  // A guarded write in the cycle of the last key byte still meets the old key,
  // so hosts leave one idle cycle before the first protected write.
  // Settings are levels from the memory mirror; a change shows one edge later.

  // Little-endian assembly of the key
  assign enteredKey = {keyByteHigh_reg, keyByteThird_reg,
                       keyByteSecond_reg, keyByteLow_reg};

  // Shared address match helper
  function automatic logic hits(input logic [7:0] a, input logic [7:0] b);
    hits = (a == b);
  endfunction

  // Lock decision on the same terms the comparator registers its gate on
  function automatic logic lockNow(input pwl_nv_s nv, input logic [31:0] key);
    lockNow = (nv.enable == LOCK_ENABLE_VALUE) && (key != nv.storedKey);
  endfunction

  // Comparator sits in its own module; its own lock flag stays open, because
  // the status flag below must change in the very cycle the gate does, and a
  // second register stage behind the comparator would lag it by one cycle
  pwl_key_compare u_compare (
    .clk          (clk),
    .rst          (rst),
    .enteredKey   (enteredKey),
    .nvSettings   (nvSettings),
    .lockActive   (),
    .writeAllowed (allowRaw)
  );

  assign refreshCount_done = (refreshCnt_reg >= REFRESH_COUNT - 1);
  // Key window spans all four key offsets
  assign keyWrite = hostReq.wrEn
                    && (hostReq.addr >= KEY_BYTE0_OFFSET)
                    && (hostReq.addr <= KEY_BYTE3_OFFSET);
  // Key bytes themselves stay writable, otherwise a lock could never open
  // Every other offset counts as guarded, unmapped ones too, so the strobe
  // can serve the time and configuration registers elsewhere in the device
  // without a second address decode there
  assign protectedWrite = hostReq.wrEn && !keyWrite;

  // Refresh timer counts only while refreshing
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      refreshCnt_reg <= 32'h0000_0000;
    end
    // Counter parks at its end value, so the clear happens only once
    else if (state_reg == PWL_REFRESH && !refreshCount_done)
    begin
      refreshCnt_reg <= refreshCnt_reg + 32'h0000_0001;
    end
  end

  // Sequencing: wait out refresh, clear key once, then run
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PWL_REFRESH:
      begin
        if (refreshCount_done)
        begin
          state_next = PWL_CLEAR;
        end
      end
      PWL_CLEAR:
      begin
        // One cycle of clearing, then normal running
        state_next = PWL_RUN;
      end
      PWL_RUN:
      begin
        // Stays here until the next reset
        state_next = PWL_RUN;
      end
      default:
      begin
        // Illegal code falls back to refresh
        state_next = PWL_REFRESH;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= PWL_REFRESH;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Key bytes; the post-refresh clear beats any host write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      keyByteLow_reg    <= KEY_BYTE_RESET;
      keyByteSecond_reg <= KEY_BYTE_RESET;
      keyByteThird_reg  <= KEY_BYTE_RESET;
      keyByteHigh_reg   <= KEY_BYTE_RESET;
    end
    // Power-up clear wipes whatever the host sent during refresh
    else if (state_reg == PWL_CLEAR)
    begin
      keyByteLow_reg    <= KEY_BYTE_RESET;
      keyByteSecond_reg <= KEY_BYTE_RESET;
      keyByteThird_reg  <= KEY_BYTE_RESET;
      keyByteHigh_reg   <= KEY_BYTE_RESET;
    end
    // Host key writes are never lock-guarded
    else if (hostReq.wrEn)
    begin
      // Each byte lands in its own lane
      if (hits(hostReq.addr, KEY_BYTE0_OFFSET))
      begin
        keyByteLow_reg <= hostReq.wrData;
      end
      if (hits(hostReq.addr, KEY_BYTE1_OFFSET))
      begin
        keyByteSecond_reg <= hostReq.wrData;
      end
      if (hits(hostReq.addr, KEY_BYTE2_OFFSET))
      begin
        keyByteThird_reg <= hostReq.wrData;
      end
      if (hits(hostReq.addr, KEY_BYTE3_OFFSET))
      begin
        keyByteHigh_reg <= hostReq.wrData;
      end
    end
  end

  // Memory address register, guarded by the lock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      nvmByteAddress <= NVM_ADDR_RESET;
    end
    // A refused write leaves the old address in place
    else if (protectedWrite && allowRaw && hits(hostReq.addr, NVM_ADDR_OFFSET))
    begin
      nvmByteAddress <= hostReq.wrData;
    end
  end

  // Memory data register; engine read-back wins over a host write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      nvmByteData <= NVM_DATA_RESET;  // Any value is legal here; zero chosen
    end
    // Engine return first; a host write in that same cycle is lost
    else if (nvDataLoad)
    begin
      nvmByteData <= nvDataIn;
    end
    else if (protectedWrite && allowRaw && hits(hostReq.addr, NVM_DATA_OFFSET))
    begin
      nvmByteData <= hostReq.wrData;
    end
  end

  // Strobe for other guarded registers in the device
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      protWriteEnable <= 1'b0;
    end
    else
    begin
      // One pulse per allowed guarded write
      protWriteEnable <= protectedWrite && allowRaw;
    end
  end

  // Read strobe answered one cycle later
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdValid <= 1'b0;
    end
    else
    begin
      rdValid <= hostReq.rdEn;
    end
  end

  // Read data; key bytes never leave the block
  // Follows the address every cycle, so rdData means something only with rdValid
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdData <= READ_ZERO;
    end
    else
    begin
      // Only the two memory registers are visible
      if (hits(hostReq.addr, NVM_ADDR_OFFSET))
      begin
        rdData <= nvmByteAddress;
      end
      else if (hits(hostReq.addr, NVM_DATA_OFFSET))
      begin
        rdData <= nvmByteData;
      end
      else
      begin
        rdData <= READ_ZERO;
      end
    end
  end

  // Lock status; reset value agrees with the closed gate
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lockActive <= 1'b1;
    end
    else
    begin
      // Same inputs and same edge as the gate, so it is always its inverse
      lockActive <= lockNow(nvSettings, enteredKey);
    end
  end

  // Power-up sequencing finished, key clear included
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      refreshDone <= 1'b0;
    end
    else
    begin
      refreshDone <= (state_reg == PWL_RUN);
    end
  end

endmodule

// file: verification/pwl_write_lock_chk.sv
`timescale 1ns/1ps
// Watches the register port of the write lock
module pwl_write_lock_chk
  import pwl_pkg::*;
(
  input logic       clk,
  input logic       rst,
  input pwl_req_s   hostReq,
  input pwl_nv_s    nvSettings,
  input logic       nvDataLoad,
  input logic [7:0] nvDataIn,
  input logic [7:0] rdData,
  input logic       rdValid,
  input logic       protWriteEnable,
  input logic       lockActive,
  input logic       refreshDone,
  input logic [7:0] nvmByteAddress,
  input logic [7:0] nvmByteData
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Request decode helpers
  wire isKey  = hostReq.addr inside {[KEY_BYTE0_OFFSET:KEY_BYTE3_OFFSET]};
  wire wrAddr = hostReq.wrEn && hostReq.addr == NVM_ADDR_OFFSET;
  a_read_answer: assert property (hostReq.rdEn |=> rdValid)
    else $error("read not answered");
  a_key_reads_zero: assert property (hostReq.rdEn && isKey |=> rdData == READ_ZERO)
    else $error("key byte readable");
  a_addr_readback: assert property (hostReq.rdEn && hostReq.addr == NVM_ADDR_OFFSET
    |=> rdData == $past(nvmByteAddress)) else $error("address readback wrong");
  a_lock_off: assert property (nvSettings.enable != LOCK_ENABLE_VALUE [*3] |-> !lockActive)
    else $error("lock without enable");
  a_locked_write_held: assert property (lockActive && wrAddr
    |=> $stable(nvmByteAddress) && !protWriteEnable) else $error("locked write landed");
  a_open_write_lands: assert property (!lockActive && refreshDone && wrAddr
    |=> nvmByteAddress == $past(hostReq.wrData) && protWriteEnable) else $error("write lost");
  a_data_load: assert property (nvDataLoad |=> nvmByteData == $past(nvDataIn))
    else $error("fetched byte lost");
  a_key_write_quiet: assert property (hostReq.wrEn && isKey |=> !protWriteEnable)
    else $error("key write flagged");
  // Main scenarios
  c_locked: cover property (lockActive && wrAddr);
  c_open: cover property (!lockActive && wrAddr);
  c_load: cover property (nvDataLoad);
endmodule

bind pwl_write_lock pwl_write_lock_chk u_chk (.clk, .rst, .hostReq, .nvSettings, .nvDataLoad,
  .nvDataIn, .rdData, .rdValid, .protWriteEnable, .lockActive, .refreshDone, .nvmByteAddress,
  .nvmByteData);

// file: verification/pwl_nvm_model.sv
`timescale 1ns/1ps
// Config memory side: lock settings mirror and direct byte return
module pwl_nvm_model
  import pwl_pkg::*;
(
  input  logic        clk,
  input  logic        rst,
  input  logic        lockOn,
  input  logic [31:0] key,
  input  logic        fetch,
  input  logic [7:0]  addr,
  output pwl_nv_s     nv,
  output logic        load,
  output logic [7:0]  data
);
  // Enable location holds 255 only when locking is wanted
  assign nv = '{enable: lockOn ? LOCK_ENABLE_VALUE : 8'h00, storedKey: key};
  // Byte comes a cycle after fetch; the line churns otherwise, never stale
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      load <= 1'b0;
    else
      load <= fetch;
    data <= fetch ? ~addr : ~data;
  end
endmodule

// file: verification/pwl_write_lock_bench.sv
`timescale 1ns/1ps
// Host register sequences against the write lock
module pwl_write_lock_bench
  import pwl_pkg::*;
;
  logic        clk = 0, rst = 1, lockOn = 1, fetch = 0;
  logic [31:0] key = 32'h0;
  pwl_req_s    req = '0;
  pwl_nv_s     nv;
  logic        ld, rdValid, pwe, lockAct, refDone;
  logic [7:0]  ldData, rdData, addrQ, dataQ;
  int          failures = 0, total_checks = 0;
  initial forever #12.5 clk = ~clk;
  pwl_nvm_model u_nvm (.clk, .rst, .lockOn, .key, .fetch, .addr(addrQ), .nv, .load(ld),
    .data(ldData));
  // Short refresh keeps the run brief
  pwl_write_lock #(.REFRESH_COUNT(20)) u_dut (.clk, .rst, .hostReq(req), .nvSettings(nv),
    .nvDataLoad(ld), .nvDataIn(ldData), .rdData, .rdValid, .protWriteEnable(pwe),
    .lockActive(lockAct), .refreshDone(refDone), .nvmByteAddress(addrQ), .nvmByteData(dataQ));
  // Compare and count
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One byte write, strobe held for a single edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    req <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(posedge clk);
    req.wrEn <= 1'b0;
  endtask
  // One byte read, answer looked at in its single valid cycle
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    req <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    @(posedge clk);
    req.rdEn <= 1'b0;
    #1 check(8'(rdValid), 8'h01);
    check(rdData, e);
  endtask
  // Key sent low byte first, then the registered compare settles
  task automatic sendKey(logic [31:0] k, logic expLock);
    for (int i = 0; i < 4; i++)
      wr(KEY_BYTE0_OFFSET + 8'(i), k[8*i +: 8]);
    repeat (2) @(posedge clk);
    #1 check(8'(lockAct), 8'(expLock));
  endtask
  task automatic summarize;
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, well beyond the sequence length
  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    summarize;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(NVM_ADDR_OFFSET, NVM_ADDR_RESET);
    rd(8'h30, READ_ZERO);
    wr(KEY_BYTE0_OFFSET, 8'h55);
    repeat (2) @(posedge clk);
    #1 check(8'(lockAct), 8'h01);
    for (int i = 0; i < 40 && refDone !== 1'b1; i++)
      @(posedge clk);
    repeat (3) @(posedge clk);
    #1 check(8'(lockAct), 8'h00);
    check(8'(refDone), 8'h01);
    @(posedge clk) key <= 32'hC3A51E7F;
    wr(NVM_ADDR_OFFSET, 8'h11);
    rd(NVM_ADDR_OFFSET, 8'h00);
    sendKey(32'h7F1EA5C3, 1'b1);
    sendKey(32'hC3A51E7F, 1'b0);
    wr(NVM_ADDR_OFFSET, 8'h5A);
    rd(NVM_ADDR_OFFSET, 8'h5A);
    for (int i = 0; i < 4; i++)
      rd(KEY_BYTE0_OFFSET + 8'(i), READ_ZERO);
    // Single command, issued only with the engine idle and none pending
    @(posedge clk) fetch <= 1'b1;
    @(posedge clk) fetch <= 1'b0;
    @(posedge clk);
    rd(NVM_DATA_OFFSET, 8'hA5);
    @(posedge clk) lockOn <= 1'b0;
    key <= 32'h00000001;
    repeat (3) @(posedge clk);
    #1 check(8'(lockAct), 8'h00);
    wr(NVM_DATA_OFFSET, 8'h3C);
    rd(NVM_DATA_OFFSET, 8'h3C);
    @(posedge clk) lockOn <= 1'b1;
    wr(NVM_DATA_OFFSET, 8'hC7);
    rd(NVM_DATA_OFFSET, 8'h3C);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(NVM_ADDR_OFFSET, NVM_ADDR_RESET);
    summarize;
  end
endmodule
